/* File: bench/pfc_feature_ctrl_monitor.sv */
// Checker of call handshake, status and feature-driven outputs
module pfc_feature_ctrl_monitor
    import pfc_pkg::*;
(
    input wire logic        clk_sys,
    input wire logic        rst_n,
    input wire logic        feature_query_call,
    input wire logic        feature_write_call,
    input wire logic        call_arg_bad,
    input wire logic        call_done,
    input wire logic [7:0]  call_status,
    input wire logic        bus_error_evt,
    input wire logic        machine_check_abort,
    input wire logic        bus_error_sig_en,
    input wire logic        bus_error_pin,
    input wire logic        bus_init_sig_en,
    input wire logic        bus_initialization_pin,
    input wire logic        abort_sig_en,
    input wire logic        abort_raise,
    input wire logic [63:0] current_settings_vector,
    input wire logic        cache_bypass,
    input wire logic        snoop_force_miss,
    input wire logic        dynamic_power_gating_en
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    chk_done_cause: assert property (call_done ==
        $past(feature_query_call || feature_write_call)) else $error("done");
    chk_dual_call: assert property (feature_query_call &&
        feature_write_call && !call_arg_bad |=>
        call_status == PFC_ST_ERROR) else $error("dual call status");
    chk_err_promo: assert property (bus_error_evt && bus_init_sig_en
        ##1 current_settings_vector[63] |-> bus_initialization_pin)
        else $error("bus error promotion");
    chk_abort_err: assert property (machine_check_abort &&
        bus_error_sig_en ##1 current_settings_vector[62] |-> bus_error_pin)
        else $error("abort promotion");
    chk_err_off: assert property (!bus_error_sig_en |=>
        !bus_error_pin) else $error("bus error disabled");
    chk_init_off: assert property (!bus_init_sig_en |=>
        !bus_initialization_pin) else $error("bus init disabled");
    chk_abort_off: assert property (!abort_sig_en |=>
        !abort_raise) else $error("abort disabled");
    chk_cache_snoop: assert property (cache_bypass ==
        current_settings_vector[59] && snoop_force_miss ==
        (current_settings_vector[59] || current_settings_vector[58]))
        else $error("cache");
    chk_gating_bit: assert property (dynamic_power_gating_en !=
        current_settings_vector[57]) else $error("gating");
    chk_reserved_zero: assert property (
        current_settings_vector[55:0] == 56'h0) else $error("reserved");
endmodule : pfc_feature_ctrl_monitor

bind pfc_feature_ctrl pfc_feature_ctrl_monitor mon_u (.clk_sys, .rst_n,
    .feature_query_call, .feature_write_call, .call_arg_bad, .call_done,
    .call_status, .bus_error_evt, .machine_check_abort, .bus_error_sig_en,
    .bus_error_pin, .bus_init_sig_en, .bus_initialization_pin,
    .abort_sig_en, .abort_raise, .current_settings_vector,
    .cache_bypass, .snoop_force_miss, .dynamic_power_gating_en);

/* File: bench/testbench.sv */
// Self-checking bench for the processor feature control block
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    import pfc_pkg::*;
    logic        clk_sys, rst_n, feature_query_call, feature_write_call;
    logic        call_arg_bad, call_done, bus_error_pin, abort_raise;
    logic        bus_initialization_pin, cache_bypass, coh_req_block;
    logic        snoop_force_miss, dynamic_power_gating_en;
    logic [1:0]  ent;
    logic [2:0]  en;
    logic [3:0]  evt;
    logic [7:0]  call_status;
    logic [63:0] feature_select, implemented_features_vector;
    logic [63:0] current_settings_vector, controllable_features_vector;
    int          err_total = 0, samples_checked = 0, cyc = 0;
    // Bits 58 and 57 tied into one group
    pfc_feature_ctrl #(.GROUP_MASK(64'h0600_0000_0000_0000)) dut_u (
        .clk_sys, .rst_n, .feature_query_call, .feature_write_call,
        .call_arg_bad, .feature_select, .call_done, .call_status,
        .implemented_features_vector, .current_settings_vector,
        .controllable_features_vector, .machine_check_handler_entry(ent[1]),
        .init_handler_entry(ent[0]), .bus_error_sig_en(en[2]),
        .bus_init_sig_en(en[1]), .abort_sig_en(en[0]),
        .bus_error_evt(evt[3]), .machine_check_abort(evt[2]),
        .corrected_check_interrupt(evt[1]), .internal_timeout_evt(evt[0]),
        .bus_error_pin, .bus_initialization_pin, .abort_raise, .cache_bypass,
        .coh_req_block, .snoop_force_miss, .dynamic_power_gating_en);
    ////////////////////////////////////////////////////////////////////////
    task automatic complete_run();
        if (err_total == 0 && samples_checked > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : complete_run
    task automatic cmp(logic [63:0] got, logic [63:0] exp);
        samples_checked++;
        if (got !== exp) begin
            err_total++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : cmp
    // Vectors settle one edge after the call edge, so wait out both
    task automatic call(logic q, logic w, logic b, logic [63:0] s,
                        logic [7:0] st);
        {feature_query_call, feature_write_call, call_arg_bad} = {q, w, b};
        feature_select = s;
        @(negedge clk_sys);
        {feature_query_call, feature_write_call, call_arg_bad} = 3'h0;
        cmp({55'h0, call_done, call_status}, {56'h1, st});
        @(negedge clk_sys);
    endtask : call
    task automatic ev(logic [3:0] e, logic [2:0] exp);
        evt = e;
        @(negedge clk_sys);
        evt = 4'h0;
        cmp({61'h0, bus_error_pin, bus_initialization_pin, abort_raise},
            {61'h0, exp});
        @(negedge clk_sys);
    endtask : ev
    ////////////////////////////////////////////////////////////////////////
    initial begin
        clk_sys = 1'b0;
        forever #2.5 clk_sys = ~clk_sys;
    end
    always @(posedge clk_sys) begin
        cyc++;
        if (cyc == 2000) begin
            err_total++;
            complete_run();
        end
    end
    initial begin
        rst_n = 1'b0;
        {feature_query_call, feature_write_call, call_arg_bad} = 3'h0;
        feature_select = 64'h0;
        {ent, en, evt} = 9'h070;
        repeat (5) @(negedge clk_sys);
        rst_n = 1'b1;
        repeat (2) @(negedge clk_sys);
        cmp(implemented_features_vector, PFC_IMPL_DEFAULT);
        cmp(controllable_features_vector, PFC_CTRL_DEFAULT);
        cmp(current_settings_vector, 64'h0);
        cmp({60'h0, cache_bypass, coh_req_block, snoop_force_miss,
             dynamic_power_gating_en}, 64'h1);
        ev(4'h8, 3'h4);
        ev(4'h4, 3'h1);
        ev(4'h1, 3'h2);
        ev(4'h2, 3'h0);
        call(1'b1, 1'b0, 1'b0, 64'h0, PFC_ST_OK);
        call(1'b1, 1'b1, 1'b0, 64'he000_0000_0000_0000,
             PFC_ST_ERROR);
        cmp(current_settings_vector, 64'he000_0000_0000_0000);
        ev(4'h8, 3'h6);
        ev(4'h4, 3'h7);
        call(1'b0, 1'b1, 1'b1, 64'h0, PFC_ST_BAD_ARG);
        cmp(current_settings_vector, 64'he000_0000_0000_0000);
        call(1'b0, 1'b1, 1'b0, 64'hf1ff_ffff_ffff_ffff, PFC_ST_OK);
        cmp(current_settings_vector, 64'hf100_0000_0000_0000);
        ev(4'h2, 3'h7);
        ev(4'h1, 3'h0);
        ent = 2'h3;
        @(negedge clk_sys);
        ent = 2'h0;
        @(negedge clk_sys);
        cmp(current_settings_vector, 64'hf100_0000_0000_0000);
        call(1'b0, 1'b1, 1'b0, 64'hf500_0000_0000_0000, PFC_ST_OK);
        cmp(current_settings_vector, 64'hf700_0000_0000_0000);
        cmp({60'h0, cache_bypass, coh_req_block, snoop_force_miss,
             dynamic_power_gating_en}, 64'h2);
        call(1'b0, 1'b1, 1'b0, 64'hff00_0000_0000_0000, PFC_ST_OK);
        cmp({60'h0, cache_bypass, coh_req_block, snoop_force_miss,
             dynamic_power_gating_en}, 64'he);
        // Clearing one group member clears its partner as well
        call(1'b0, 1'b1, 1'b0, 64'hfb00_0000_0000_0000, PFC_ST_OK);
        cmp(current_settings_vector, 64'hf900_0000_0000_0000);
        cmp({60'h0, cache_bypass, coh_req_block, snoop_force_miss,
             dynamic_power_gating_en}, 64'hf);
        en = 3'h5;
        ev(4'h8, 3'h4);
        en = 3'h1;
        ev(4'h4, 3'h1);
        en = 3'h0;
        ev(4'h2, 3'h0);
        // Mid-run reset must drop every controllable setting
        rst_n = 1'b0;
        @(negedge clk_sys);
        rst_n = 1'b1;
        @(negedge clk_sys);
        cmp(current_settings_vector, 64'h0);
        cmp({60'h0, cache_bypass, coh_req_block, snoop_force_miss,
             dynamic_power_gating_en}, 64'h1);
        complete_run();
    end
endmodule : testbench

/* File: rtl/pfc_feature_ctrl.sv */
// Processor feature control: query/set calls and feature-driven signalling
//
// Function
// [RQ1] Report 64-bit implemented-features vector, one bit per feature.
// [RQ2] Report current-settings vector with same positions, live state.
// [RQ3] Report controllable vector; only those bits change on a set call.
// [RQ4] Query status: 0 success, -2 invalid argument, -3 error.
// [RQ5] Enabling or disabling any group member does so for whole group.
// [RQ6] Control attribute counts only for implemented features.
// [RQ7] Controllable bits are 0 after reset; check/init entries keep them.
// [RQ8] Bit 63 set: bus error also asserts bus init, if init enabled.
// [RQ9] Bit 62 set: machine check abort asserts bus error, if enabled.
// [RQ10] Bit 61 set: machine check abort asserts bus init, if enabled.
// [RQ11] Bit 60 set: corrected interrupt becomes abort, then promotions.
// [RQ12] Bit 59 set: bypass cache, no coherence requests, snoops miss.
// [RQ13] Bit 58 set: every coherency request answered as line absent.
// [RQ14] Bit 57 clear permits idle unit gating; set keeps all clocks.
// [RQ15] Bit 56 set: internal time-out bus init is silently discarded.
// [RQ16] Set requests for non-controllable features are ignored.
// [RQ17] Reserved bits read zero in all vectors; writes to them ignored.
module pfc_feature_ctrl
    import pfc_pkg::*;
#(
    parameter logic [63:0] IMPL_MASK  = PFC_IMPL_DEFAULT,
    parameter logic [63:0] CTRL_MASK  = PFC_CTRL_DEFAULT,
    parameter logic [63:0] GROUP_MASK = PFC_GROUP_DEFAULT
) (
    input  wire logic        clk_sys,
    input  wire logic        rst_n,
    // Call port
    input  wire logic        feature_query_call,
    input  wire logic        feature_write_call,
    input  wire logic        call_arg_bad,
    input  wire logic [63:0] feature_select,
    output logic             call_done,
    output logic [7:0]       call_status,
    output logic [63:0]      implemented_features_vector,
    output logic [63:0]      current_settings_vector,
    output logic [63:0]      controllable_features_vector,
    // Firmware entries
    input  wire logic        machine_check_handler_entry,
    input  wire logic        init_handler_entry,
    // Signalling enables from the bus feature block
    input  wire logic        bus_error_sig_en,
    input  wire logic        bus_init_sig_en,
    input  wire logic        abort_sig_en,
    // Events, one-cycle pulses from core logic
    input  wire logic        bus_error_evt,
    input  wire logic        machine_check_abort,
    input  wire logic        corrected_check_interrupt,
    input  wire logic        internal_timeout_evt,
    // Pins and controls
    output logic             bus_error_pin,
    output logic             bus_initialization_pin,
    output logic             abort_raise,
    output logic             cache_bypass,
    output logic             coh_req_block,
    output logic             snoop_force_miss,
    output logic             dynamic_power_gating_en
);

    ////////////////////////////////////////////////////////////////////////
    // Masks and settings
    ////////////////////////////////////////////////////////////////////////

    // Control attribute only counts where the feature exists
    localparam logic [63:0] IMPL_EFF = IMPL_MASK & PFC_DEFINED_MASK; // [RQ17]
    localparam logic [63:0] CTRL_EFF = CTRL_MASK & IMPL_EFF; // [RQ6]
    localparam logic [63:0] GRP_EFF  = GROUP_MASK & CTRL_EFF;

    logic [63:0] settings_reg;
    logic [63:0] settings_next;
    logic        sel_bad;

    pfc_group_merge #(
        .W (PFC_VEC_W)
    ) u_merge (
        .req_vec     (feature_select),
        .old_vec     (settings_reg),
        .change_mask (CTRL_EFF),
        .group_mask  (GRP_EFF),
        .merged_vec  (settings_next)
    ); // [RQ5]

    // Selecting a feature that does not exist is an invalid argument for a set call
    assign sel_bad = |(feature_select & ~IMPL_EFF & PFC_DEFINED_MASK);

    // Handler entries do not touch the settings, only reset and set calls do
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            settings_reg <= PFC_SETTINGS_RESET; // [RQ7]
        end else if (feature_write_call && !call_arg_bad && !sel_bad) begin
            settings_reg <= settings_next; // [RQ3] [RQ16]
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Call answers
    ////////////////////////////////////////////////////////////////////////

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            call_done   <= 1'b0;
            call_status <= PFC_ST_OK;
        end else begin
            call_done <= feature_query_call | feature_write_call;
            if (feature_query_call || feature_write_call) begin
                if (call_arg_bad) begin
                    call_status <= PFC_ST_BAD_ARG; // [RQ4]
                end else if (feature_query_call && feature_write_call) begin
                    call_status <= PFC_ST_ERROR; // [RQ4]
                end else if (feature_write_call && sel_bad) begin
                    call_status <= PFC_ST_BAD_ARG;
                end else begin
                    call_status <= PFC_ST_OK; // [RQ4]
                end
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            implemented_features_vector  <= 64'h0000_0000_0000_0000;
            controllable_features_vector <= 64'h0000_0000_0000_0000;
            current_settings_vector      <= PFC_SETTINGS_RESET;
        end else begin
            implemented_features_vector  <= IMPL_EFF; // [RQ1] [RQ17]
            controllable_features_vector <= CTRL_EFF; // [RQ3] [RQ17]
            current_settings_vector <= settings_reg & IMPL_EFF; // [RQ2]
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Error promotion
    ////////////////////////////////////////////////////////////////////////

    logic abort_eff;
    logic err_eff;
    logic init_eff;

    always_comb begin
        // Corrected interrupt joins the abort path only with aborts enabled
        abort_eff = machine_check_abort |
                    (corrected_check_interrupt &
                     settings_reg[PFC_BIT_CORR_PROMO] &
                     abort_sig_en); // [RQ11]
        err_eff   = bus_error_evt |
                    (abort_eff & settings_reg[PFC_BIT_ABT_ERR]); // [RQ9]
        init_eff  = (bus_error_evt &
                     settings_reg[PFC_BIT_ERR_PROMO]) | // [RQ8]
                    (abort_eff & settings_reg[PFC_BIT_ABT_INIT]) | // [RQ10]
                    (internal_timeout_evt &
                     !settings_reg[PFC_BIT_TMO_INIT_DIS]); // [RQ15]
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            bus_error_pin          <= 1'b0;
            bus_initialization_pin <= 1'b0;
            abort_raise            <= 1'b0;
        end else begin
            abort_raise            <= abort_eff & abort_sig_en; // [RQ11]
            bus_error_pin          <= err_eff & bus_error_sig_en; // [RQ9]
            bus_initialization_pin <= init_eff & bus_init_sig_en; // [RQ8]
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Cache, coherency and clock gating controls
    ////////////////////////////////////////////////////////////////////////

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            cache_bypass            <= 1'b0;
            coh_req_block           <= 1'b0;
            snoop_force_miss        <= 1'b0;
            dynamic_power_gating_en <= 1'b1;
        end else begin
            cache_bypass     <= settings_reg[PFC_BIT_CACHE_DIS]; // [RQ12]
            coh_req_block    <= settings_reg[PFC_BIT_CACHE_DIS]; // [RQ12]
            snoop_force_miss <= settings_reg[PFC_BIT_CACHE_DIS] |
                                settings_reg[PFC_BIT_COH_DIS]; // [RQ12] [RQ13]
            dynamic_power_gating_en <=
                !settings_reg[PFC_BIT_GATING_DIS]; // [RQ14]
        end
    end

    // Handler entry strobes are accepted but deliberately change nothing
    logic unused_entries;
    assign unused_entries = machine_check_handler_entry | init_handler_entry;

endmodule : pfc_feature_ctrl

/* File: rtl/pfc_group_merge.sv */
// Group tie logic: a group member that flips sets or clears the whole group to its new level
module pfc_group_merge
    import pfc_pkg::*;
#(
    parameter int unsigned W = 64
) (
    input  wire logic [W-1:0] req_vec,
    input  wire logic [W-1:0] old_vec,
    input  wire logic [W-1:0] change_mask,
    input  wire logic [W-1:0] group_mask,
    output logic      [W-1:0] merged_vec
);
    logic [W-1:0] grp_changed;
    logic         grp_on;
    logic         grp_hit;

    always_comb begin
        grp_changed = (req_vec ^ old_vec) & group_mask;
        grp_hit     = |grp_changed;
        // The flipped member dictates the group level
        grp_on      = |(grp_changed & req_vec);
        merged_vec  = req_vec;
        if (grp_hit) begin
            merged_vec = (req_vec & ~group_mask) |
                         (grp_on ? group_mask : {W{1'b0}});
        end
        merged_vec = (merged_vec & change_mask) | (old_vec & ~change_mask);
    end
endmodule : pfc_group_merge

/* File: rtl/pfc_pkg.sv */
// Package: constants for the processor feature control block
package pfc_pkg;
    localparam int unsigned PFC_VEC_W      = 64;
    // Feature bit positions
    localparam int unsigned PFC_BIT_ERR_PROMO    = 63;
    localparam int unsigned PFC_BIT_ABT_ERR      = 62;
    localparam int unsigned PFC_BIT_ABT_INIT     = 61;
    localparam int unsigned PFC_BIT_CORR_PROMO   = 60;
    localparam int unsigned PFC_BIT_CACHE_DIS    = 59;
    localparam int unsigned PFC_BIT_COH_DIS      = 58;
    localparam int unsigned PFC_BIT_GATING_DIS   = 57;
    localparam int unsigned PFC_BIT_TMO_INIT_DIS = 56;
    // Features modelled by this block occupy bits 63..56
    localparam logic [63:0] PFC_DEFINED_MASK     = 64'hff00_0000_0000_0000;
    localparam logic [63:0] PFC_IMPL_DEFAULT     = 64'hff00_0000_0000_0000;
    localparam logic [63:0] PFC_CTRL_DEFAULT     = 64'hff00_0000_0000_0000;
    localparam logic [63:0] PFC_GROUP_DEFAULT    = 64'h0000_0000_0000_0000;
    localparam logic [63:0] PFC_SETTINGS_RESET   = 64'h0000_0000_0000_0000;
    // Call status codes, two's complement in 8 bits
    localparam logic [7:0]  PFC_ST_OK            = 8'h00;
    localparam logic [7:0]  PFC_ST_BAD_ARG       = 8'hfe;
    localparam logic [7:0]  PFC_ST_ERROR         = 8'hfd;
endpackage : pfc_pkg
